//--- core/acr_defines.vh
`ifndef ACR_DEFINES_VH
`define ACR_DEFINES_VH
`define ACR_OFS_CTRL_A 5'h00
`define ACR_OFS_CTRL_B 5'h01
`define ACR_OFS_CTRL_C 5'h02
`define ACR_OFS_CTRL_D 5'h03
`define ACR_OFS_INT_EN 5'h04
`define ACR_OFS_INT_FLAGS 5'h05
`define ACR_OFS_STATUS 5'h06
`define ACR_OFS_DEBUG 5'h07
`define ACR_OFS_SAMP_DUR 5'h08
`define ACR_OFS_CTRL_F 5'h09
`define ACR_OFS_COMMAND 5'h0A
`define ACR_OFS_GAIN 5'h0B
`define ACR_OFS_MUX_POS 5'h0C
`define ACR_OFS_MUX_NEG 5'h0D
`define ACR_OFS_RESULT0 5'h10
`define ACR_OFS_RESULT1 5'h11
`define ACR_OFS_RESULT2 5'h12
`define ACR_OFS_RESULT3 5'h13
`define ACR_OFS_SAMPLE0 5'h14
`define ACR_OFS_SAMPLE1 5'h15
`define ACR_OFS_SCRATCH0 5'h18
`define ACR_OFS_SCRATCH1 5'h19
`define ACR_OFS_SCRATCH2 5'h1A
`define ACR_OFS_WIN_LO0 5'h1C
`define ACR_OFS_WIN_LO1 5'h1D
`define ACR_OFS_WIN_HI0 5'h1E
`define ACR_OFS_WIN_HI1 5'h1F
`define ACR_BIT_ENABLE 0
`define ACR_BIT_LOW_LAT 5
`define ACR_BIT_STBY_RUN 7
`define ACR_BIT_DEBUG_RUN 0
`define ACR_CTRL_A_MASK 8'hA1
`define ACR_DEBUG_MASK 8'h01
`define ACR_BYTE_RESET 8'h00
`define ACR_ZERO_BYTE 8'h00
`endif

//--- core/acr_sync2.v
`timescale 1ns/1ps
module acr_sync2 #(
    parameter WIDTH = 1
) (
    input wire sys_clk_i,
    input wire rst_b_i,
    input wire [WIDTH-1:0] d_i,
    output wire [WIDTH-1:0] q_o
);
    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_r <= {WIDTH{1'b0}};
            sync_r <= {WIDTH{1'b0}};
        end else begin
            meta_r <= d_i;
            sync_r <= meta_r;
        end
    end
    assign q_o = sync_r;
endmodule // acr_sync2

//--- core/acr_byte_reg.v
`timescale 1ns/1ps
`include "acr_defines.vh"
module acr_byte_reg #(
    parameter [7:0] MASK = 8'hFF
) (
    input wire sys_clk_i,
    input wire rst_b_i,
    input wire we_i,
    input wire [7:0] wdata_i,
    output wire [7:0] q_o
);
    reg [7:0] val_r;
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            val_r <= `ACR_BYTE_RESET;
        end else if (we_i) begin
            val_r <= wdata_i & MASK;
        end
    end
    assign q_o = val_r;
endmodule // acr_byte_reg

//--- core/acr_bank.v
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "acr_defines.vh"
module acr_bank (
    input wire sys_clk_i,
    input wire rst_b_i,
    input wire [4:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    input wire standby_sleep_i,
    input wire deep_sleep_state_i,
    input wire debug_halt_i,
    input wire conv_start_i,
    input wire conv_done_i,
    input wire inputs_selected_i,
    input wire [31:0] result_i,
    input wire [15:0] sample_i,
    input wire [7:0] int_flags_i,
    output wire int_flags_clr_o,
    output reg conv_run_o,
    output reg conv_abort_o,
    output reg analog_power_o,
    output wire [7:0] prescale_o,
    output wire [7:0] ref_timebase_o,
    output wire [7:0] window_mode_o,
    output wire [7:0] int_enables_o,
    output wire [7:0] sample_dur_o,
    output wire [7:0] accum_o,
    output wire [7:0] command_o,
    output wire [7:0] gain_o,
    output wire [7:0] mux_pos_o,
    output wire [7:0] mux_neg_o,
    output wire [15:0] win_lo_o,
    output wire [15:0] win_hi_o
);
    localparam NREG = 17;
    localparam ST_OFF = 3'b001;
    localparam ST_RUN = 3'b010;
    localparam ST_CONV = 3'b100;

    reg rst_m_r;
    reg rst_s_r;
    wire rst_b;
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_m_r <= 1'b0;
            rst_s_r <= 1'b0;
        end else begin
            rst_m_r <= 1'b1;
            rst_s_r <= rst_m_r;
        end
    end
    assign rst_b = rst_s_r;

    wire [2:0] pin_sync;
    acr_sync2 #(.WIDTH(3)) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b),
        .d_i({standby_sleep_i, deep_sleep_state_i, debug_halt_i}),
        .q_o(pin_sync)
    );
    wire stby = pin_sync[2];
    wire deep = pin_sync[1];
    wire dbg = pin_sync[0];

    // One flop byte per writable offset except the flags offset, whose write only strobes a clear; reserved bits masked off on write
    wire [7:0] q [0:NREG+1];

    acr_byte_reg #(.MASK(`ACR_CTRL_A_MASK)) u_ctrl_a (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b),
        .we_i(wr_i && addr_i == `ACR_OFS_CTRL_A),
        .wdata_i(wdata_i),
        .q_o(q[0])
    );
    acr_byte_reg u_ctrl_b (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b),
        .we_i(wr_i && addr_i == `ACR_OFS_CTRL_B),
        .wdata_i(wdata_i),
        .q_o(q[1])
    );
    acr_byte_reg u_ctrl_c (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b),
        .we_i(wr_i && addr_i == `ACR_OFS_CTRL_C),
        .wdata_i(wdata_i),
        .q_o(q[2])
    );
    acr_byte_reg u_ctrl_d (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b),
        .we_i(wr_i && addr_i == `ACR_OFS_CTRL_D),
        .wdata_i(wdata_i),
        .q_o(q[3])
    );
    acr_byte_reg u_int_en (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b),
        .we_i(wr_i && addr_i == `ACR_OFS_INT_EN),
        .wdata_i(wdata_i),
        .q_o(q[4])
    );
    acr_byte_reg #(.MASK(`ACR_DEBUG_MASK)) u_debug (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b),
        .we_i(wr_i && addr_i == `ACR_OFS_DEBUG),
        .wdata_i(wdata_i),
        .q_o(q[5])
    );
    acr_byte_reg u_samp_dur (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b),
        .we_i(wr_i && addr_i == `ACR_OFS_SAMP_DUR),
        .wdata_i(wdata_i),
        .q_o(q[6])
    );
    acr_byte_reg u_ctrl_f (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b),
        .we_i(wr_i && addr_i == `ACR_OFS_CTRL_F),
        .wdata_i(wdata_i),
        .q_o(q[7])
    );
    acr_byte_reg u_command (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b),
        .we_i(wr_i && addr_i == `ACR_OFS_COMMAND),
        .wdata_i(wdata_i),
        .q_o(q[8])
    );
    acr_byte_reg u_gain (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b),
        .we_i(wr_i && addr_i == `ACR_OFS_GAIN),
        .wdata_i(wdata_i),
        .q_o(q[9])
    );
    acr_byte_reg u_mux_pos (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b),
        .we_i(wr_i && addr_i == `ACR_OFS_MUX_POS),
        .wdata_i(wdata_i),
        .q_o(q[10])
    );
    acr_byte_reg u_mux_neg (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b),
        .we_i(wr_i && addr_i == `ACR_OFS_MUX_NEG),
        .wdata_i(wdata_i),
        .q_o(q[11])
    );
    acr_byte_reg u_scratch0 (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b),
        .we_i(wr_i && addr_i == `ACR_OFS_SCRATCH0),
        .wdata_i(wdata_i),
        .q_o(q[12])
    );
    acr_byte_reg u_scratch1 (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b),
        .we_i(wr_i && addr_i == `ACR_OFS_SCRATCH1),
        .wdata_i(wdata_i),
        .q_o(q[13])
    );
    acr_byte_reg u_scratch2 (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b),
        .we_i(wr_i && addr_i == `ACR_OFS_SCRATCH2),
        .wdata_i(wdata_i),
        .q_o(q[14])
    );
    acr_byte_reg u_lo0 (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b),
        .we_i(wr_i && addr_i == `ACR_OFS_WIN_LO0),
        .wdata_i(wdata_i),
        .q_o(q[15])
    );
    acr_byte_reg u_lo1 (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b),
        .we_i(wr_i && addr_i == `ACR_OFS_WIN_LO1),
        .wdata_i(wdata_i),
        .q_o(q[16])
    );
    acr_byte_reg u_hi0 (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b),
        .we_i(wr_i && addr_i == `ACR_OFS_WIN_HI0),
        .wdata_i(wdata_i),
        .q_o(q[NREG])
    );
    acr_byte_reg u_hi1 (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b),
        .we_i(wr_i && addr_i == `ACR_OFS_WIN_HI1),
        .wdata_i(wdata_i),
        .q_o(q[NREG+1])
    );

    wire enable = q[0][`ACR_BIT_ENABLE];
    wire low_latency = q[0][`ACR_BIT_LOW_LAT];
    wire standby_run = q[0][`ACR_BIT_STBY_RUN];
    wire debug_run = q[5][`ACR_BIT_DEBUG_RUN];
    assign prescale_o = q[1];
    assign ref_timebase_o = q[2];
    assign window_mode_o = q[3];
    assign int_enables_o = q[4];
    assign sample_dur_o = q[6];
    assign accum_o = q[7];
    assign command_o = q[8];
    assign gain_o = q[9];
    assign mux_pos_o = q[10];
    assign mux_neg_o = q[11];
    assign win_lo_o = {q[16], q[15]};
    assign win_hi_o = {q[NREG+1], q[NREG]};
    // Flag clearing is done by the flag owner, strobed on any write to the flags offset whatever the data
    assign int_flags_clr_o = wr_i && addr_i == `ACR_OFS_INT_FLAGS;

    // Halt request: standby without run, or debug halt without run
    wire halt_req = (stby && !standby_run) || (dbg && !debug_run);

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_OFF: begin
                if (enable && !deep && !halt_req) state_nxt = ST_RUN;
            end
            ST_RUN: begin
                if (!enable || deep || halt_req) state_nxt = ST_OFF;
                else if (conv_start_i) state_nxt = ST_CONV;
            end
            ST_CONV: begin
                if (!enable || deep) state_nxt = ST_OFF;
                // Halt waits for the running conversion to end
                else if (conv_done_i) state_nxt = halt_req ? ST_OFF : ST_RUN;
            end
            default: state_nxt = ST_OFF;
        endcase
    end

    always @(posedge sys_clk_i or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_OFF;
            conv_run_o <= 1'b0;
            conv_abort_o <= 1'b0;
            analog_power_o <= 1'b0;
        end else begin
            state_r <= state_nxt;
            conv_run_o <= (state_nxt != ST_OFF);
            conv_abort_o <= (state_r == ST_CONV) && (deep || !enable);
            // Power costs idle current when held; latency traded for it
            if (state_nxt == ST_CONV) analog_power_o <= 1'b1;
            else if (state_nxt == ST_RUN) analog_power_o <= low_latency && inputs_selected_i;
            else analog_power_o <= enable && low_latency && standby_run && stby && !deep
                && inputs_selected_i;
        end
    end

    reg [7:0] rd_nxt;
    always @* begin
        rd_nxt = `ACR_ZERO_BYTE;
        case (addr_i)
            `ACR_OFS_CTRL_A: rd_nxt = q[0];
            `ACR_OFS_CTRL_B: rd_nxt = q[1];
            `ACR_OFS_CTRL_C: rd_nxt = q[2];
            `ACR_OFS_CTRL_D: rd_nxt = q[3];
            `ACR_OFS_INT_EN: rd_nxt = q[4];
            `ACR_OFS_DEBUG: rd_nxt = q[5];
            `ACR_OFS_SAMP_DUR: rd_nxt = q[6];
            `ACR_OFS_CTRL_F: rd_nxt = q[7];
            `ACR_OFS_COMMAND: rd_nxt = q[8];
            `ACR_OFS_GAIN: rd_nxt = q[9];
            `ACR_OFS_MUX_POS: rd_nxt = q[10];
            `ACR_OFS_MUX_NEG: rd_nxt = q[11];
            `ACR_OFS_SCRATCH0: rd_nxt = q[12];
            `ACR_OFS_SCRATCH1: rd_nxt = q[13];
            `ACR_OFS_SCRATCH2: rd_nxt = q[14];
            `ACR_OFS_WIN_LO0: rd_nxt = q[15];
            `ACR_OFS_WIN_LO1: rd_nxt = q[16];
            `ACR_OFS_WIN_HI0: rd_nxt = q[NREG];
            `ACR_OFS_WIN_HI1: rd_nxt = q[NREG+1];
            `ACR_OFS_INT_FLAGS: rd_nxt = int_flags_i;
            `ACR_OFS_STATUS: rd_nxt = {7'h00, state_r == ST_CONV};
            `ACR_OFS_RESULT0: rd_nxt = result_i[7:0];
            `ACR_OFS_RESULT1: rd_nxt = result_i[15:8];
            `ACR_OFS_RESULT2: rd_nxt = result_i[23:16];
            `ACR_OFS_RESULT3: rd_nxt = result_i[31:24];
            `ACR_OFS_SAMPLE0: rd_nxt = sample_i[7:0];
            `ACR_OFS_SAMPLE1: rd_nxt = sample_i[15:8];
            default: rd_nxt = rd_nxt;
        endcase
    end

    always @(posedge sys_clk_i or negedge rst_b) begin
        if (!rst_b) begin
            rdata_o <= `ACR_ZERO_BYTE;
        end else begin
            rdata_o <= rd_i ? rd_nxt : `ACR_ZERO_BYTE;
        end
    end
endmodule // acr_bank

//--- verification/acr_bank_monitor.sv
`timescale 1ns/1ps
module acr_bank_monitor (
    input wire sys_clk_i,
    input wire rst_b_i,
    input wire [4:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] rdata_o,
    input wire inputs_selected_i,
    input wire conv_run_o,
    input wire analog_power_o
);
    reg [7:0] ctl_r;
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctl_r <= 8'h00;
        end else if (wr_i && addr_i == 5'h00) begin
            ctl_r <= wdata_i & 8'hA1;
        end
    end
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    run_off_a:
        assert property (!ctl_r[0] |=> !conv_run_o) else $error("run while disabled");
    run_rise_a:
        assert property ($rose(conv_run_o) |-> $past(ctl_r[0])) else $error("start while disabled");
    ctrl_read_a:
        assert property (rd_i && addr_i == 5'h00 |=> rdata_o == $past(ctl_r)) else $error("ctrl");
    ctrl_unused_a:
        assert property (rd_i && addr_i == 5'h00 |=> (rdata_o & 8'h5E) == 8'h00) else $error("bits");
    debug_mask_a:
        assert property (rd_i && addr_i == 5'h07 |=> rdata_o[7:1] == 7'h00) else $error("debug");
    unmapped_zero_a:
        assert property (rd_i && addr_i inside {5'h0E, 5'h0F, 5'h16, 5'h17, 5'h1B}
            |=> rdata_o == 8'h00) else $error("unmapped");
    power_idle_a:
        assert property (!ctl_r[5] && !$past(ctl_r[5]) && !conv_run_o && !$past(conv_run_o)
            |-> !analog_power_o) else $error("power idle");
    power_kept_a:
        assert property (ctl_r[5] && $stable(ctl_r) && conv_run_o && $past(conv_run_o)
            && inputs_selected_i && $past(inputs_selected_i) |-> analog_power_o)
            else $error("power kept");
endmodule // acr_bank_monitor
bind acr_bank acr_bank_monitor i_mon (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .inputs_selected_i(inputs_selected_i), .conv_run_o(conv_run_o),
    .analog_power_o(analog_power_o));

//--- verification/test_acr_bank.sv
`timescale 1ns/1ps
module test_acr_bank;
    reg clk = 0, rst_b = 0, wr = 0, rd = 0, sby = 0, dsl = 0, dbh = 0, cst = 0, cdn = 0, sel = 0;
    reg [4:0] a = 0;
    reg [7:0] d = 0, q;
    reg seen = 0;
    wire [7:0] rdata;
    wire run, abt, pwr, clr;
    wire [7:0] pre;
    wire [15:0] whi;
    reg [7:0] nclr = 0;
    integer errors = 0, checks_done = 0, cyc = 0, i;
    reg [20:0] rows [0:7];
    acr_bank i_dut (.sys_clk_i(clk), .rst_b_i(rst_b), .addr_i(a), .wdata_i(d), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .standby_sleep_i(sby), .deep_sleep_state_i(dsl),
        .debug_halt_i(dbh), .conv_start_i(cst), .conv_done_i(cdn), .inputs_selected_i(sel),
        .result_i(32'hA5000000), .sample_i(16'h5A3C), .int_flags_i(8'h2C),
        .int_flags_clr_o(clr), .conv_run_o(run), .conv_abort_o(abt), .analog_power_o(pwr),
        .prescale_o(pre), .ref_timebase_o(), .window_mode_o(), .int_enables_o(), .sample_dur_o(),
        .accum_o(), .command_o(), .gain_o(), .mux_pos_o(), .mux_neg_o(), .win_lo_o(),
        .win_hi_o(whi));
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (abt) begin
            seen <= 1'b1;
        end
        if (clr) begin
            nclr <= nclr + 8'h01;
        end
        if (cyc == 3000) begin
            errors = errors + 1;
            print_verdict;
        end
    end
    task print_verdict;
        begin
            $display("checks %0d errors %0d", checks_done, errors);
            if (errors == 0 && checks_done > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task chk(input [47:0] nm, input [7:0] e, input [7:0] g);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("Error %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task w(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    task wr_b(input [4:0] ad, input [7:0] v);
        begin
            @(posedge clk);
            wr <= 1'b1;
            a <= ad;
            d <= v;
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    task rd_b(input [4:0] ad);
        begin
            @(posedge clk);
            rd <= 1'b1;
            a <= ad;
            @(posedge clk);
            rd <= 1'b0;
            #1 q = rdata;
        end
    endtask
    task pulse(input s);
        begin
            if (s) cst <= 1'b1;
            else cdn <= 1'b1;
            w(1);
            cst <= 1'b0;
            cdn <= 1'b0;
        end
    endtask
    initial begin
        rows[0] = {5'h00, 8'hFF, 8'hA1};
        rows[1] = {5'h07, 8'hFF, 8'h01};
        rows[2] = {5'h01, 8'h5A, 8'h5A};
        rows[3] = {5'h1F, 8'hC3, 8'hC3};
        rows[4] = {5'h0E, 8'hFF, 8'h00};
        rows[5] = {5'h13, 8'h3C, 8'hA5};
        rows[6] = {5'h05, 8'h00, 8'h2C};
        rows[7] = {5'h15, 8'h00, 8'h5A};
        w(2);
        rst_b <= 1'b1;
        w(3);
        rd_b(5'h00);
        chk("reset", 8'h00, q);
        for (i = 0; i < 8; i = i + 1) begin
            wr_b(rows[i][20:16], rows[i][15:8]);
            rd_b(rows[i][20:16]);
            chk("rdback", rows[i][7:0], q);
        end
        chk("presc", 8'h5A, pre);
        chk("winhi", 8'hC3, whi[15:8]);
        chk("flgclr", 8'h01, nclr);
        $display("registers done");
        sel <= 1'b1;
        wr_b(5'h00, 8'h00);
        w(2);
        chk("run", 8'h00, {7'h00, run});
        wr_b(5'h00, 8'h01);
        w(2);
        chk("run", 8'h01, {7'h00, run});
        chk("power", 8'h00, {7'h00, pwr});
        pulse(1);
        sby <= 1'b1;
        w(5);
        chk("power", 8'h01, {7'h00, pwr});
        rd_b(5'h06);
        chk("busy", 8'h01, q);
        pulse(0);
        w(2);
        chk("run", 8'h00, {7'h00, run});
        wr_b(5'h00, 8'hA1);
        w(5);
        chk("run", 8'h01, {7'h00, run});
        chk("power", 8'h01, {7'h00, pwr});
        sby <= 1'b0;
        w(5);
        chk("power", 8'h01, {7'h00, pwr});
        $display("power done");
        pulse(1);
        dsl <= 1'b1;
        w(5);
        chk("abort", 8'h01, {7'h00, seen});
        chk("run", 8'h00, {7'h00, run});
        dsl <= 1'b0;
        dbh <= 1'b1;
        w(6);
        chk("run", 8'h01, {7'h00, run});
        wr_b(5'h07, 8'h00);
        w(4);
        chk("run", 8'h00, {7'h00, run});
        dbh <= 1'b0;
        $display("sleep done");
        w(4);
        chk("run", 8'h01, {7'h00, run});
        rst_b <= 1'b0;
        w(1);
        chk("rstrun", 8'h00, {7'h00, run});
        chk("rstpwr", 8'h00, {7'h00, pwr});
        rst_b <= 1'b1;
        w(3);
        rd_b(5'h00);
        chk("reset", 8'h00, q);
        $display("reset done");
        print_verdict;
    end
endmodule // test_acr_bank
